// File: pkg/bil_pkg.sv
package bil_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int unsigned BOOT_DELAY_NS = 15000;
  localparam int unsigned BOOT_DELAY_CYC = (BOOT_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned LINK_EN_DELAY_NS = 200;
  localparam int unsigned LINK_EN_CYC = (LINK_EN_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SPI_HZ = 2_500_000;
  localparam int unsigned SPI_HALF_CYC = CLK_HZ / (2 * SPI_HZ);
  localparam int unsigned STRAP_SAMPLE_EDGE = 3;

  // Image format and check value
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_SKIP = 32'h0d15ab1e;
  localparam logic [31:0] NULL_CHAN = 32'h0000ff02;
  localparam logic [7:0] END_TOKEN = 8'h01;
  localparam logic [7:0] FLASH_READ_CMD = 8'h03;
  localparam logic [23:0] FLASH_ADDR = 24'h000000;
  localparam logic [5:0] FLASH_CMD_BITS = 6'h20;
  localparam logic [3:0] LINK_SYM_LAST = 4'h8;
  localparam int unsigned SEC_BOOT_BIT = 5;

  // Reset values
  localparam logic [31:0] RAM_BOOT_ADDR = 32'h00000000;
  localparam logic [31:0] OTP_BOOT_ADDR = 32'h00000000;

  typedef enum logic [1:0] {
    SRC_JTAG = 2'b00,
    SRC_RSVD = 2'b01,
    SRC_LINK = 2'b10,
    SRC_SPI = 2'b11
  } bil_src_t;

  typedef struct packed {
    bil_src_t src;
    logic [1:0] pll_sel;
  } bil_strap_t;

  typedef struct packed {
    logic [2:0] od;
    logic [11:0] f;
    logic [5:0] r;
  } bil_pll_t;

  localparam bil_pll_t PLL_SEL00 = '{od: 3'h1, f: 12'h07a, r: 6'h00};
  localparam bil_pll_t PLL_SEL11 = '{od: 3'h2, f: 12'h077, r: 6'h00};
  localparam bil_pll_t PLL_SEL10 = '{od: 3'h2, f: 12'h031, r: 6'h00};
  localparam bil_pll_t PLL_SEL01 = '{od: 3'h2, f: 12'h017, r: 6'h00};

  typedef struct packed {
    logic vld;
    logic ctrl;
    logic [7:0] data;
  } bil_byte_t;

  typedef enum logic [3:0] {
    ST_RESET = 4'b0000,
    ST_SELECT = 4'b0001,
    ST_LINK_WAIT = 4'b0010,
    ST_CHAN = 4'b0011,
    ST_SIZE = 4'b0100,
    ST_PROG = 4'b0101,
    ST_CRC = 4'b0110,
    ST_END_RX = 4'b0111,
    ST_ACK = 4'b1000,
    ST_RUN = 4'b1001,
    ST_FAIL = 4'b1010,
    ST_JTAG = 4'b1011,
    ST_RSVD = 4'b1100
  } bil_state_t;

endpackage : bil_pkg

// File: rtl/bil_crc_byte.sv
`timescale 1ns/1ps
// One byte through the reflected check register, low bit first
module bil_crc_byte
  import bil_pkg::*;
(
  input wire logic [31:0] crc_in,
  input wire logic [7:0] data_in,
  output logic [31:0] crc_out
);

  // Eight serial steps unrolled by the loop
  always_comb begin
    crc_out = crc_in;
    for (int i = 0; i < 8; i++) begin
      if (crc_out[0] ^ data_in[i]) begin
        crc_out = (crc_out >> 1) ^ CRC_POLY;
      end else begin
        crc_out = crc_out >> 1;
      end
    end
  end

endmodule : bil_crc_byte

// File: rtl/bil_loader.sv
`timescale 1ns/1ps
module bil_loader
  import bil_pkg::*;
#(
  parameter int RAM_AW = 14,
  parameter int OTP_AW = 11
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic link_clk_in,
  input wire logic [3:0] mode_strap_in,
  input wire logic [31:0] security_word_in,
  output logic gpio_pull_en_out,
  output logic [2:0] pll_output_divider_out,
  output logic [11:0] pll_feedback_out,
  output logic [5:0] pll_ref_div_out,
  output logic spi_sclk_out,
  output logic spi_sclk_oe_n_out,
  output logic spi_cs_n_out,
  output logic spi_cs_oe_n_out,
  output logic spi_mosi_out,
  output logic spi_mosi_oe_n_out,
  input wire logic spi_miso_in,
  output logic link_out_wire_0_out,
  output logic link_out_wire_0_oe_n_out,
  output logic link_out_wire_1_out,
  output logic link_out_wire_1_oe_n_out,
  input wire logic link_in_wire_0_in,
  input wire logic link_in_wire_1_in,
  output logic link_pulldown_en_out,
  output logic otp_rd_out,
  output logic [OTP_AW-1:0] otp_addr_out,
  input wire logic [31:0] otp_data_in,
  output logic ram_we_out,
  output logic [RAM_AW-1:0] ram_addr_out,
  output logic [31:0] ram_wdata_out,
  output logic run_out,
  output logic [RAM_AW-1:0] run_addr_out,
  output logic boot_busy_out,
  output logic boot_fail_out,
  output logic [1:0] boot_source_out,
  output logic secure_boot_out
);

  // Strap synchroniser and capture
  logic [3:0] strap_s1_ff, strap_s2_ff;
  logic [1:0] edge_cnt_ff, nxt_edge_cnt;
  bil_strap_t strap_ff, nxt_strap;
  bil_pll_t pll_ff, nxt_pll;

  always_comb begin
    nxt_edge_cnt = edge_cnt_ff;
    nxt_strap = strap_ff;
    nxt_pll = pll_ff;
    if (edge_cnt_ff != 2'(STRAP_SAMPLE_EDGE)) begin
      nxt_edge_cnt = edge_cnt_ff + 2'h1;
    end
    // Third edge after release catches the straps
    if (edge_cnt_ff == 2'(STRAP_SAMPLE_EDGE - 1)) begin
      nxt_strap = bil_strap_t'(strap_s2_ff);
      case (strap_s2_ff[1:0])
        2'b00: nxt_pll = PLL_SEL00;
        2'b11: nxt_pll = PLL_SEL11;
        2'b10: nxt_pll = PLL_SEL10;
        default: nxt_pll = PLL_SEL01;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    strap_s1_ff <= mode_strap_in;
    strap_s2_ff <= strap_s1_ff;
    if (reset_in) begin
      edge_cnt_ff <= 2'h0;
      strap_ff <= '0;
      pll_ff <= PLL_SEL00;
    end else begin
      edge_cnt_ff <= nxt_edge_cnt;
      strap_ff <= nxt_strap;
      pll_ff <= nxt_pll;
    end
  end

  // Core sequencer state, declared early for the byte engines
  bil_state_t state_ff, nxt_state;
  bil_src_t src_ff, nxt_src;
  logic secure_ff, nxt_secure;
  logic fetch;
  logic spi_go, otp_go, link_mode;

  assign fetch = (state_ff == ST_SIZE) || (state_ff == ST_PROG) || (state_ff == ST_CRC);
  assign link_mode = !secure_ff && (src_ff == SRC_LINK);
  assign spi_go = fetch && !secure_ff && (src_ff == SRC_SPI);
  assign otp_go = fetch && secure_ff;

  // Flash master and OTP reader
  logic miso_s1_ff, miso_s2_ff;
  logic sp_act_ff, nxt_sp_act;
  logic [7:0] sp_div_ff, nxt_sp_div;
  logic sclk_ff, nxt_sclk;
  logic cs_n_ff, nxt_cs_n;
  logic mosi_ff, nxt_mosi;
  logic [31:0] sp_tx_ff, nxt_sp_tx;
  logic [5:0] sp_bit_ff, nxt_sp_bit;
  logic [7:0] sp_rx_ff, nxt_sp_rx;
  logic [2:0] sp_rxn_ff, nxt_sp_rxn;
  logic ot_rd_ff, nxt_ot_rd;
  logic ot_pend_ff, nxt_ot_pend;
  logic [OTP_AW-1:0] ot_addr_ff, nxt_ot_addr;
  logic [31:0] ot_word_ff, nxt_ot_word;
  logic [2:0] ot_left_ff, nxt_ot_left;
  bil_byte_t sp_byte, ot_byte;
  logic [31:0] sp_init;

  assign sp_init = {FLASH_ADDR, FLASH_READ_CMD};

  always_comb begin
    nxt_sp_act = sp_act_ff;
    nxt_sp_div = sp_div_ff;
    nxt_sclk = sclk_ff;
    nxt_cs_n = cs_n_ff;
    nxt_mosi = mosi_ff;
    nxt_sp_tx = sp_tx_ff;
    nxt_sp_bit = sp_bit_ff;
    nxt_sp_rx = sp_rx_ff;
    nxt_sp_rxn = sp_rxn_ff;
    sp_byte = '0;
    if (!spi_go && !sclk_ff) begin // A high half runs out first, no runt pulse
      nxt_sp_act = 1'b0;
      nxt_sclk = 1'b0;
      nxt_cs_n = 1'b1;
      nxt_sp_div = 8'h00;
    end else if (!sp_act_ff) begin
      // First bit set up before the first rising edge
      nxt_sp_act = 1'b1;
      nxt_cs_n = 1'b0;
      nxt_mosi = sp_init[0];
      nxt_sp_tx = sp_init >> 1;
      nxt_sp_bit = 6'h00;
      nxt_sp_rxn = 3'h0;
    end else if (sp_div_ff == 8'(SPI_HALF_CYC - 1)) begin
      nxt_sp_div = 8'h00;
      nxt_sclk = !sclk_ff;
      if (!sclk_ff) begin
        // Rising edge samples, idle low clock
        if (sp_bit_ff != FLASH_CMD_BITS) begin
          nxt_sp_bit = sp_bit_ff + 6'h01;
        end else begin
          nxt_sp_rx = {miso_s2_ff, sp_rx_ff[7:1]};
          nxt_sp_rxn = sp_rxn_ff + 3'h1;
          sp_byte.vld = (sp_rxn_ff == 3'h7);
          sp_byte.data = {miso_s2_ff, sp_rx_ff[7:1]};
        end
      end else begin
        // Falling edge moves the next command bit out
        nxt_mosi = sp_tx_ff[0];
        nxt_sp_tx = sp_tx_ff >> 1;
      end
    end else begin
      nxt_sp_div = sp_div_ff + 8'h01;
    end
  end

  // OTP words split into bytes, low byte first
  always_comb begin
    nxt_ot_rd = 1'b0;
    nxt_ot_pend = ot_rd_ff;
    nxt_ot_addr = ot_addr_ff;
    nxt_ot_word = ot_word_ff;
    nxt_ot_left = ot_left_ff;
    ot_byte = '0;
    if (ot_left_ff != 3'h0) begin
      ot_byte.vld = 1'b1;
      ot_byte.data = ot_word_ff[7:0];
      nxt_ot_word = ot_word_ff >> 8;
      nxt_ot_left = ot_left_ff - 3'h1;
    end else if (ot_pend_ff) begin
      nxt_ot_word = otp_data_in;
      nxt_ot_left = 3'h4;
      nxt_ot_addr = ot_addr_ff + 1'b1;
    end else if (otp_go && !ot_rd_ff) begin
      nxt_ot_rd = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    miso_s1_ff <= spi_miso_in;
    miso_s2_ff <= miso_s1_ff;
    if (reset_in) begin
      sp_act_ff <= 1'b0;
      sp_div_ff <= 8'h00;
      sclk_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      mosi_ff <= 1'b0;
      sp_tx_ff <= 32'h00000000;
      sp_bit_ff <= 6'h00;
      sp_rx_ff <= 8'h00;
      sp_rxn_ff <= 3'h0;
      ot_rd_ff <= 1'b0;
      ot_pend_ff <= 1'b0;
      ot_addr_ff <= OTP_AW'(OTP_BOOT_ADDR);
      ot_word_ff <= 32'h00000000;
      ot_left_ff <= 3'h0;
    end else begin
      sp_act_ff <= nxt_sp_act;
      sp_div_ff <= nxt_sp_div;
      sclk_ff <= nxt_sclk;
      cs_n_ff <= nxt_cs_n;
      mosi_ff <= nxt_mosi;
      sp_tx_ff <= nxt_sp_tx;
      sp_bit_ff <= nxt_sp_bit;
      sp_rx_ff <= nxt_sp_rx;
      sp_rxn_ff <= nxt_sp_rxn;
      ot_rd_ff <= nxt_ot_rd;
      ot_pend_ff <= nxt_ot_pend;
      ot_addr_ff <= nxt_ot_addr;
      ot_word_ff <= nxt_ot_word;
      ot_left_ff <= nxt_ot_left;
    end
  end

  // Link events into the system domain by toggle synchronisers
  logic rx_tgl_ff, tx_done_tgl_ff;
  logic [8:0] rx_sym_ff;
  logic [2:0] rx_tgl_s_ff, done_tgl_s_ff;
  logic lk_evt, done_evt;
  bil_byte_t lk_byte, src_byte;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rx_tgl_s_ff <= 3'h0;
      done_tgl_s_ff <= 3'h0;
    end else begin
      rx_tgl_s_ff <= {rx_tgl_s_ff[1:0], rx_tgl_ff};
      done_tgl_s_ff <= {done_tgl_s_ff[1:0], tx_done_tgl_ff};
    end
  end

  // Symbol held nine link clocks, far longer than the sync delay
  assign lk_evt = rx_tgl_s_ff[2] ^ rx_tgl_s_ff[1];
  assign done_evt = done_tgl_s_ff[2] ^ done_tgl_s_ff[1];
  assign lk_byte = '{vld: lk_evt, ctrl: rx_sym_ff[0], data: rx_sym_ff[8:1]};
  assign src_byte = secure_ff ? ot_byte : (link_mode ? lk_byte : sp_byte);

  // Boot sequencer
  logic [15:0] dly_ff, nxt_dly;
  logic [1:0] bcnt_ff, nxt_bcnt;
  logic [31:0] word_ff, nxt_word, w_full;
  logic [31:0] size_ff, nxt_size, waddr_ff, nxt_waddr;
  logic [31:0] crc_ff, nxt_crc, crc_upd, chan_ff, nxt_chan;
  logic pull_ff, nxt_pull, link_en_ff, nxt_link_en, spi_en_ff, nxt_spi_en;
  logic we_ff, nxt_we, tx_tgl_ff, nxt_tx_tgl;
  logic [RAM_AW-1:0] ram_addr_ff, nxt_ram_addr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic data_evt, word_done;

  bil_crc_byte u_crc (
    .crc_in(crc_ff),
    .data_in(src_byte.data),
    .crc_out(crc_upd)
  );

  assign data_evt = src_byte.vld && !src_byte.ctrl;
  assign word_done = data_evt && (bcnt_ff == 2'h3);
  assign w_full = {src_byte.data, word_ff[31:8]};

  always_comb begin
    nxt_state = state_ff;
    nxt_src = src_ff;
    nxt_secure = secure_ff;
    nxt_dly = dly_ff;
    nxt_bcnt = bcnt_ff;
    nxt_word = word_ff;
    nxt_size = size_ff;
    nxt_waddr = waddr_ff;
    nxt_crc = crc_ff;
    nxt_chan = chan_ff;
    nxt_pull = pull_ff;
    nxt_link_en = link_en_ff;
    nxt_spi_en = spi_en_ff;
    nxt_we = 1'b0;
    nxt_tx_tgl = tx_tgl_ff;
    nxt_ram_addr = ram_addr_ff;
    nxt_wdata = wdata_ff;
    // Bytes of any word-bearing state assemble low byte first
    if (fetch || state_ff == ST_CHAN) begin
      if (data_evt) begin
        nxt_bcnt = bcnt_ff + 2'h1;
        nxt_word = w_full;
      end
      if (data_evt && (state_ff == ST_SIZE || state_ff == ST_PROG)) begin
        nxt_crc = crc_upd;
      end
    end
    case (state_ff)
      ST_RESET: begin
        if (dly_ff == 16'(BOOT_DELAY_CYC - 1)) begin
          nxt_pull = 1'b1;
          nxt_dly = 16'h0000;
          nxt_state = ST_SELECT;
        end else begin
          nxt_dly = dly_ff + 16'h0001;
        end
      end
      ST_SELECT: begin
        nxt_src = strap_ff.src;
        nxt_secure = security_word_in[SEC_BOOT_BIT];
        if (security_word_in[SEC_BOOT_BIT]) begin
          nxt_state = ST_SIZE;
        end else begin
          case (strap_ff.src)
            SRC_JTAG: nxt_state = ST_JTAG;
            SRC_RSVD: nxt_state = ST_RSVD;
            SRC_LINK: nxt_state = ST_LINK_WAIT;
            default: begin
              nxt_spi_en = 1'b1;
              nxt_state = ST_SIZE;
            end
          endcase
        end
      end
      ST_LINK_WAIT: begin
        nxt_dly = dly_ff + 16'h0001;
        if (dly_ff == 16'(LINK_EN_CYC - 2)) begin
          nxt_link_en = 1'b1;
          nxt_state = ST_CHAN;
        end
      end
      ST_CHAN: begin
        if (word_done) begin
          nxt_chan = w_full;
          nxt_state = ST_SIZE;
        end
      end
      ST_SIZE: begin
        if (word_done) begin
          nxt_size = w_full;
          nxt_waddr = RAM_BOOT_ADDR;
          nxt_state = (w_full == 32'h00000000) ? ST_CRC : ST_PROG;
        end
      end
      ST_PROG: begin
        if (word_done) begin
          nxt_we = 1'b1;
          nxt_wdata = w_full;
          nxt_ram_addr = waddr_ff[RAM_AW-1:0];
          nxt_waddr = waddr_ff + 32'h00000001;
          if (waddr_ff + 32'h00000001 == size_ff) begin
            nxt_state = ST_CRC;
          end
        end
      end
      ST_CRC: begin
        if (word_done) begin
          if (w_full == CRC_SKIP || w_full == ~crc_ff) begin
            nxt_state = link_mode ? ST_END_RX : ST_RUN;
          end else begin
            nxt_state = ST_FAIL;
          end
        end
      end
      ST_END_RX: begin
        if (src_byte.vld && src_byte.ctrl && src_byte.data == END_TOKEN) begin
          if (chan_ff == NULL_CHAN) begin
            nxt_state = ST_RUN;
          end else begin
            nxt_tx_tgl = !tx_tgl_ff;
            nxt_state = ST_ACK;
          end
        end
      end
      ST_ACK: begin
        if (done_evt) begin
          nxt_state = ST_RUN;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_ff <= ST_RESET;
      src_ff <= SRC_JTAG;
      secure_ff <= 1'b0;
      dly_ff <= 16'h0000;
      bcnt_ff <= 2'h0;
      word_ff <= 32'h00000000;
      size_ff <= 32'h00000000;
      waddr_ff <= RAM_BOOT_ADDR;
      crc_ff <= CRC_INIT;
      chan_ff <= 32'h00000000;
      pull_ff <= 1'b0;
      link_en_ff <= 1'b0;
      spi_en_ff <= 1'b0;
      we_ff <= 1'b0;
      tx_tgl_ff <= 1'b0;
      ram_addr_ff <= '0;
      wdata_ff <= 32'h00000000;
    end else begin
      state_ff <= nxt_state;
      src_ff <= nxt_src;
      secure_ff <= nxt_secure;
      dly_ff <= nxt_dly;
      bcnt_ff <= nxt_bcnt;
      word_ff <= nxt_word;
      size_ff <= nxt_size;
      waddr_ff <= nxt_waddr;
      crc_ff <= nxt_crc;
      chan_ff <= nxt_chan;
      pull_ff <= nxt_pull;
      link_en_ff <= nxt_link_en;
      spi_en_ff <= nxt_spi_en;
      we_ff <= nxt_we;
      tx_tgl_ff <= nxt_tx_tgl;
      ram_addr_ff <= nxt_ram_addr;
      wdata_ff <= nxt_wdata;
    end
  end

  // Link clock domain: receive and send nine-bit symbols
  logic lk_rst_s1_ff, lk_rst_s2_ff, lk_en_s1_ff, lk_en_s2_ff;
  logic in0_s1_ff, in0_s2_ff, in1_s1_ff, in1_s2_ff;
  logic [2:0] req_s_ff;
  logic [8:0] rx_sh_ff, nxt_rx_sh, nxt_rx_sym, tx_sh_ff, nxt_tx_sh;
  logic [3:0] rx_cnt_ff, nxt_rx_cnt, tx_cnt_ff, nxt_tx_cnt;
  logic nxt_rx_tgl, tx_busy_ff, nxt_tx_busy, nxt_done_tgl;
  logic out0_ff, nxt_out0, out1_ff, nxt_out1, lk_clr;

  assign lk_clr = lk_rst_s2_ff || !lk_en_s2_ff;

  always_comb begin
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_cnt = 4'h0;
    nxt_rx_sym = rx_sym_ff;
    nxt_rx_tgl = rx_tgl_ff;
    // Wire 1 high frames a symbol, wire 0 carries its bits
    if (in1_s2_ff) begin
      nxt_rx_sh = {in0_s2_ff, rx_sh_ff[8:1]};
      nxt_rx_cnt = rx_cnt_ff + 4'h1;
      if (rx_cnt_ff == LINK_SYM_LAST) begin
        nxt_rx_sym = {in0_s2_ff, rx_sh_ff[8:1]};
        nxt_rx_tgl = !rx_tgl_ff;
        nxt_rx_cnt = 4'h0;
      end
    end
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_busy = tx_busy_ff;
    nxt_done_tgl = tx_done_tgl_ff;
    nxt_out0 = 1'b0;
    nxt_out1 = 1'b0;
    if (tx_busy_ff) begin
      nxt_out1 = 1'b1;
      nxt_out0 = tx_sh_ff[0];
      nxt_tx_sh = tx_sh_ff >> 1;
      nxt_tx_cnt = tx_cnt_ff + 4'h1;
      if (tx_cnt_ff == LINK_SYM_LAST) begin
        nxt_tx_busy = 1'b0;
        nxt_done_tgl = !tx_done_tgl_ff;
      end
    end else if (req_s_ff[2] ^ req_s_ff[1]) begin
      nxt_tx_busy = 1'b1;
      nxt_tx_sh = {END_TOKEN, 1'b1};
      nxt_tx_cnt = 4'h0;
    end
  end

  always_ff @(posedge link_clk_in) begin
    lk_rst_s1_ff <= reset_in;
    lk_rst_s2_ff <= lk_rst_s1_ff;
    lk_en_s1_ff <= link_en_ff;
    lk_en_s2_ff <= lk_en_s1_ff;
    in0_s1_ff <= link_in_wire_0_in;
    in0_s2_ff <= in0_s1_ff;
    in1_s1_ff <= link_in_wire_1_in;
    in1_s2_ff <= in1_s1_ff;
    // Disabled link holds everything but the reset, enable and wire synchronisers cleared
    if (lk_clr) begin
      req_s_ff <= 3'h0;
      rx_sh_ff <= 9'h000;
      rx_cnt_ff <= 4'h0;
      rx_sym_ff <= 9'h000;
      rx_tgl_ff <= 1'b0;
      tx_sh_ff <= 9'h000;
      tx_cnt_ff <= 4'h0;
      tx_busy_ff <= 1'b0;
      tx_done_tgl_ff <= 1'b0;
      out0_ff <= 1'b0;
      out1_ff <= 1'b0;
    end else begin
      req_s_ff <= {req_s_ff[1:0], tx_tgl_ff};
      rx_sh_ff <= nxt_rx_sh;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_sym_ff <= nxt_rx_sym;
      rx_tgl_ff <= nxt_rx_tgl;
      tx_sh_ff <= nxt_tx_sh;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_busy_ff <= nxt_tx_busy;
      tx_done_tgl_ff <= nxt_done_tgl;
      out0_ff <= nxt_out0;
      out1_ff <= nxt_out1;
    end
  end

  // Pin and status outputs
  assign gpio_pull_en_out = pull_ff;
  assign pll_output_divider_out = pll_ff.od;
  assign pll_feedback_out = pll_ff.f;
  assign pll_ref_div_out = pll_ff.r;
  assign spi_sclk_out = sclk_ff;
  assign spi_cs_n_out = cs_n_ff;
  assign spi_mosi_out = mosi_ff;
  assign spi_sclk_oe_n_out = !spi_en_ff;
  assign spi_cs_oe_n_out = !spi_en_ff;
  assign spi_mosi_oe_n_out = !spi_en_ff;
  assign link_out_wire_0_out = out0_ff;
  assign link_out_wire_1_out = out1_ff;
  assign link_out_wire_0_oe_n_out = !link_en_ff;
  assign link_out_wire_1_oe_n_out = !link_en_ff;
  assign link_pulldown_en_out = pull_ff && !link_en_ff;
  assign otp_rd_out = ot_rd_ff;
  assign otp_addr_out = ot_addr_ff;
  assign ram_we_out = we_ff;
  assign ram_addr_out = ram_addr_ff;
  assign ram_wdata_out = wdata_ff;
  assign run_out = (state_ff == ST_RUN);
  assign run_addr_out = RAM_AW'(RAM_BOOT_ADDR);
  assign boot_busy_out = (state_ff != ST_RUN) && (state_ff != ST_FAIL);
  assign boot_fail_out = (state_ff == ST_FAIL);
  assign boot_source_out = src_ff;
  assign secure_boot_out = secure_ff;

endmodule : bil_loader

// File: testbench/bil_loader_sva.sv
`timescale 1ns/1ps
// Pin watch on the loader; reset disables every property but the reset check
module bil_loader_sva #(
  parameter int RAM_AW = 14
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic spi_sclk_out,
  input wire logic spi_cs_n_out,
  input wire logic spi_cs_oe_n_out,
  input wire logic spi_mosi_out,
  input wire logic link_out_wire_0_oe_n_out,
  input wire logic link_out_wire_0_out,
  input wire logic link_out_wire_1_out,
  input wire logic link_pulldown_en_out,
  input wire logic gpio_pull_en_out,
  input wire logic otp_rd_out,
  input wire logic run_out,
  input wire logic [RAM_AW-1:0] run_addr_out,
  input wire logic boot_fail_out,
  input wire logic [1:0] boot_source_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // One high half of the flash clock, 25 cycles
  sequence sclk_half;
    spi_sclk_out ##24 spi_sclk_out ##1 !spi_sclk_out;
  endsequence
  // Reset itself is the antecedent here, so no disable
  chk_reset_hiz: assert property (@(posedge sys_clk_in) disable iff (1'b0)
    reset_in && $past(reset_in) |-> spi_cs_oe_n_out && link_out_wire_0_oe_n_out
    && !gpio_pull_en_out) else $error("pins driven in reset");
  chk_sclk_idle: assert property (spi_cs_n_out |-> !spi_sclk_out)
    else $error("flash clock high while deselected");
  chk_sclk_half: assert property ($rose(spi_sclk_out) |-> sclk_half)
    else $error("flash clock half period wrong");
  chk_mosi_hold: assert property (spi_sclk_out && !spi_cs_n_out |-> $stable(spi_mosi_out))
    else $error("flash data moved while clock high");
  chk_pull_late: assert property ($fell(reset_in) |-> !gpio_pull_en_out [*8])
    else $error("pulls on too early");
  chk_otp_space: assert property (otp_rd_out |=> !otp_rd_out [*5])
    else $error("OTP reads too close");
  chk_link_idle: assert property (!link_out_wire_0_oe_n_out |-> !link_pulldown_en_out
    && (link_out_wire_1_out || !link_out_wire_0_out)) else $error("link idle wrong");
  chk_flash_only: assert property (!spi_cs_oe_n_out |-> boot_source_out == 2'b11)
    else $error("flash pins driven for other source");
  chk_run_home: assert property (run_out |-> run_addr_out == '0 && !boot_fail_out)
    else $error("bad jump");
  chk_run_keeps: assert property (run_out |=> run_out)
    else $error("run dropped");
endmodule : bil_loader_sva
bind bil_loader bil_loader_sva #(.RAM_AW(RAM_AW)) u_sva (.sys_clk_in, .reset_in, .spi_sclk_out,
  .spi_cs_n_out, .spi_cs_oe_n_out, .spi_mosi_out, .link_out_wire_0_oe_n_out,
  .link_out_wire_0_out, .link_out_wire_1_out, .link_pulldown_en_out, .gpio_pull_en_out,
  .otp_rd_out, .run_out, .run_addr_out, .boot_fail_out, .boot_source_out);

// File: testbench/bil_flash_model.sv
`timescale 1ns/1ps
// Serial flash holding one fixed image, mode 0
module bil_flash_model (
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic [31:0] cmd_out
);
  // Size 1, one word, skip marker; fields low byte first
  logic [7:0] img [0:11] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h78, 8'h56, 8'h34, 8'h12,
    8'h1e, 8'hab, 8'h15, 8'h0d};
  int n_bit = 0;
  logic cur = 1'b0;
  // Select opens a fresh transfer
  always @(negedge cs_n_in) n_bit = 0;
  // Command sampled on rising clock, low bit first
  always @(posedge sclk_in) begin
    if (n_bit < 32) cmd_out = {mosi_in, cmd_out[31:1]};
    n_bit++;
  end
  // Change on falling clock; wraps so no unknown leaks past the image
  always @(negedge sclk_in)
    if (n_bit >= 32) cur = img[((n_bit - 32) / 8) % 12][(n_bit - 32) % 8];
  // Released line shows the inverse, never a held value
  assign miso_out = cs_n_in ? ~cur : cur;
endmodule : bil_flash_model

// File: testbench/bil_loader_bench.sv
`timescale 1ns/1ps
module bil_loader_bench;
  logic sys_clk_in = 0, link_clk_in = 0, reset_in = 1, spi_miso_in, li0 = 0, li1 = 0;
  logic [3:0] mode_strap_in = 4'h0;
  logic [31:0] security_word_in = 32'h0, otp_data_in = 32'h0, ram_wdata_out, wd, cmd;
  logic gpio_pull_en_out, spi_sclk_out, spi_sclk_oe_n_out, spi_cs_n_out, spi_cs_oe_n_out;
  logic spi_mosi_out, spi_mosi_oe_n_out, link_out_wire_0_out, link_out_wire_0_oe_n_out;
  logic link_out_wire_1_out, link_out_wire_1_oe_n_out, link_pulldown_en_out, otp_rd_out;
  logic ram_we_out, run_out, boot_busy_out, boot_fail_out, secure_boot_out;
  logic [2:0] pll_output_divider_out;
  logic [11:0] pll_feedback_out;
  logic [5:0] pll_ref_div_out;
  logic [1:0] boot_source_out;
  logic [10:0] otp_addr_out, oa0;
  logic [13:0] ram_addr_out, run_addr_out, wa;
  logic [31:0] otp [0:3] = '{32'h1, 32'hcafef00d, 32'h0, 32'h0};
  int n_mismatch = 0, comparisons = 0, n_otp = 0, nw = 0, n = 0;
  // Wire levels: select idles high, clock low when released
  wire cs_w = spi_cs_oe_n_out | spi_cs_n_out;
  wire sck_w = spi_sclk_out & ~spi_sclk_oe_n_out;
  always #4 sys_clk_in = ~sys_clk_in;
  always begin #3.7; forever #15 link_clk_in = ~link_clk_in; end
  // Inbound link wires come from the host tasks
  bil_loader dut (.*, .link_in_wire_0_in(li0), .link_in_wire_1_in(li1));
  bil_flash_model u_flash (.sclk_in(sck_w), .cs_n_in(cs_w), .mosi_in(spi_mosi_out),
    .miso_out(spi_miso_in), .cmd_out(cmd));
  // RAM writes recorded; OTP answers one cycle after the read
  always @(posedge sys_clk_in) begin
    if (ram_we_out === 1'b1) begin
      wa <= ram_addr_out;
      wd <= ram_wdata_out;
      nw++;
    end
    if (otp_rd_out === 1'b1) begin
      otp_data_in <= #1 otp[otp_addr_out[1:0]];
      if (n_otp++ == 0) oa0 <= otp_addr_out;
    end
  end
  task automatic end_sim();
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick();
    @(posedge sys_clk_in);
    #1;
  endtask : tick
  // One cycle of a bounded wait; running out ends the run
  task automatic bound();
    n++;
    if (n > 20000) begin
      n_mismatch++;
      end_sim();
    end
    tick();
  endtask : bound
  // Straps set with reset and held steady past capture
  task automatic boot(input logic [3:0] strap, input logic sec);
    tick();
    reset_in = 1'b1;
    mode_strap_in = strap;
    security_word_in = {26'h0, sec, 5'h0};
    n_otp = 0;
    nw = 0;
    repeat (16) tick();
    reset_in = 1'b0;
    n = 0;
  endtask : boot
  // Every preset, with the JTAG and reserved sources left waiting
  task automatic pll_presets();
    logic [20:0] exp [0:3] = '{{3'h1, 12'h07a, 6'h00}, {3'h2, 12'h017, 6'h00},
      {3'h2, 12'h031, 6'h00}, {3'h2, 12'h077, 6'h00}};
    for (int i = 0; i < 4; i++) begin
      boot({1'b0, i[0], i[1:0]}, 1'b0);
      while (gpio_pull_en_out !== 1'b1) bound();
      check("pull_delay", n inside {[1872:1878]}, 32'h1);
      repeat (40) tick();
      check("pll", {pll_output_divider_out, pll_feedback_out, pll_ref_div_out}, exp[i]);
      check("source", boot_source_out, {1'b0, i[0]});
      check("waiting", {boot_busy_out, run_out, spi_cs_oe_n_out}, 3'h5);
    end
  endtask : pll_presets
  // Symbol from the host: control bit first, then one idle clock
  task automatic send(input logic [8:0] s);
    for (int i = 0; i < 10; i++) begin
      @(negedge link_clk_in);
      {li1, li0} = (i < 9) ? {1'b1, s[i]} : 2'b00;
    end
  endtask : send
  // Link straps, then reply word, image and END from the host
  task automatic link_boot(input logic [31:0] chan);
    logic [31:0] w [0:3];
    logic ack;
    w = '{chan, 32'h1, 32'h9abcdef0, 32'h0d15ab1e};
    ack = 1'b0;
    boot(4'h8, 1'b0);
    while (link_out_wire_0_oe_n_out !== 1'b0) bound();
    check("link_delay", n inside {[1897:1905]}, 32'h1);
    check("link_pins", {link_pulldown_en_out, link_out_wire_0_out, link_out_wire_1_out,
      link_out_wire_1_oe_n_out, spi_cs_oe_n_out}, 5'h01);
    repeat (4) @(negedge link_clk_in);
    for (int k = 0; k < 16; k++) send({w[k / 4][k % 4 * 8 +: 8], 1'b0});
    send(9'h003);
    while (run_out !== 1'b1) begin
      ack = ack | link_out_wire_1_out;
      bound();
    end
    check("link_word", wd, 32'h9abcdef0);
    check("ack", ack, chan != 32'h0000ff02);
  endtask : link_boot
  task automatic flash_boot();
    boot(4'hd, 1'b0);
    while (run_out !== 1'b1) bound();
    check("cmd", cmd, 32'h00000003);
    check("writes", nw, 32'h1);
    check("addr", wa, 14'h0);
    check("data", wd, 32'h12345678);
    check("flash_pins", {spi_sclk_oe_n_out, spi_mosi_oe_n_out}, 2'h0);
  endtask : flash_boot
  function automatic logic [31:0] crc_of(input logic [63:0] msg);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < 64; i++)
      c = (c >> 1) ^ ((c[0] ^ msg[i]) ? 32'hedb88320 : 32'h0);
    return ~c;
  endfunction : crc_of
  // Secure bit overrides link straps; good value runs, bad one halts
  task automatic otp_boot(input logic good);
    otp[2] = crc_of({otp[1], otp[0]}) ^ {31'h0, !good};
    boot(4'hb, 1'b1);
    while (run_out !== 1'b1 && boot_fail_out !== 1'b1) bound();
    repeat (8) tick();
    check("first_otp", oa0, 11'h0);
    check("secure", {secure_boot_out, spi_cs_oe_n_out, link_out_wire_0_oe_n_out}, 3'h7);
    check("outcome", {run_out, boot_fail_out}, {good, !good});
    check("otp_data", wd, 32'hcafef00d);
  endtask : otp_boot
  initial begin
    pll_presets();
    link_boot(32'h0000ff02);
    link_boot(32'h00000102);
    flash_boot();
    otp_boot(1'b1);
    otp_boot(1'b0);
    end_sim();
  end
endmodule : bil_loader_bench
